//--- verilog/apt_consts.vh
// constants for the absolute position transfer controller
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`ifndef APT_CONSTS_VH
`define APT_CONSTS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define APT_CLK_HZ       20000000
`define APT_T_MODE_S     5
`define APT_T_REQ_S      1
`define APT_T_RDY_S      1
`define APT_T_RETRY_MS   20
`define APT_T_CLR_MS     20

// ----------------------------------------------------------------
// transfer framing
// ----------------------------------------------------------------
`define APT_DATA_GROUPS  5'd16
`define APT_ALL_GROUPS   5'd19
`define APT_MAX_TRIES    3'd4

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define APT_REG_CTRL     8'h00
`define APT_REG_STATUS   8'h04
`define APT_REG_POS      8'h08
`define APT_REG_HOME     8'h0c
`define APT_REG_IRQ_STAT 8'h10
`define APT_REG_IRQ_MASK 8'h14
`define APT_REG_BUF_A    8'h18
`define APT_REG_BUF_B    8'h1c

// control fields
`define APT_CTRL_START   0
`define APT_CTRL_HOME    1
`define APT_CTRL_REV_OK  2
`define APT_CTRL_POSGO   3

// interrupt event bits
`define APT_EV_DONE      0
`define APT_EV_COMM      1
`define APT_EV_CKS       2
`define APT_EV_HOME      3

// per-axis buffer addresses
`define APT_BUF_X_DIR    16'h0005
`define APT_BUF_X_HOME   16'h0048
`define APT_BUF_X_POS    16'h0482
`define APT_BUF_X_CMD    16'h047e
`define APT_BUF_Y_DIR    16'h009b
`define APT_BUF_Y_HOME   16'h00de
`define APT_BUF_Y_POS    16'h04b4
`define APT_BUF_Y_CMD    16'h04b0

`endif

//--- verilog/apt_tmr.v
// interval timer that flags when a level stays high too long
`default_nettype none

module apt_tmr #(
    parameter [31:0] LIMIT = 32'd20000000
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        run,
    output reg         expired
);

    reg [31:0] cnt_r;

    // ----------------------------------------------------------------
    // count while run is high, restart whenever it drops
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r   <= 32'h0000_0000;
            expired <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                cnt_r   <= 32'h0000_0000;
                expired <= 1'b0;
            end else begin
                if (cnt_r != LIMIT)
                    cnt_r <= cnt_r + 32'h0000_0001;
                expired <= (cnt_r == LIMIT); // at the limit, where the count holds
            end
        end
    end

endmodule // apt_tmr

`default_nettype wire

//--- verilog/apt_ctrl.v
// host controller for the absolute position transfer handshake
`include "apt_consts.vh"
`default_nettype none

module apt_ctrl #(
    parameter        AXIS      = 0,
    parameter [31:0] MODE_CYC  = `APT_T_MODE_S * `APT_CLK_HZ,
    parameter [31:0] REQ_CYC   = `APT_T_REQ_S * `APT_CLK_HZ,
    parameter [31:0] RDY_CYC   = `APT_T_RDY_S * `APT_CLK_HZ,
    parameter [31:0] RETRY_CYC = `APT_T_RETRY_MS * (`APT_CLK_HZ / 1000),
    parameter [31:0] CLR_CYC   = `APT_T_CLR_MS * (`APT_CLK_HZ / 1000)
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         irq,
    input  wire        servo_enable_in,
    input  wire        alarm_in,
    input  wire        estop_in,
    input  wire        home_start_switch,
    input  wire        send_ready_in,
    input  wire        data_bit0_in,
    input  wire        data_bit1_in,
    output reg         servo_on_out,
    output reg         transfer_mode_out,
    output reg         position_request_out,
    output reg         deviation_counter_clear,
    output reg         comm_error_out,
    output reg         checksum_error_out,
    output reg         position_ready_flag,
    output reg         in_position_out,
    output reg         zero_speed_out,
    output reg         torque_limit_out,
    output reg         position_start_out
);

    // ----------------------------------------------------------------
    // state codes
    // ----------------------------------------------------------------
    localparam [5:0] S_IDLE = 6'b000001;
    localparam [5:0] S_ARM  = 6'b000010;
    localparam [5:0] S_REQ  = 6'b000100;
    localparam [5:0] S_REL  = 6'b001000;
    localparam [5:0] S_CHK  = 6'b010000;
    localparam [5:0] S_WAIT = 6'b100000;

    reg [5:0]  state_r;
    reg [4:0]  grp_r;        // groups received
    reg [31:0] pos_sh_r;     // position being shifted in
    reg [5:0]  sum_r;        // running sum of data groups
    reg [5:0]  cks_r;        // checksum sent by amplifier
    reg [2:0]  tries_r;      // consecutive mismatches
    reg [31:0] wait_r;       // retry wait / clear pulse counters
    reg [31:0] clr_r;
    reg [31:0] pos_r;
    reg [31:0] home_r;
    reg [3:0]  ctrl_r;
    reg [3:0]  stat_r;
    reg [3:0]  mask_r;
    reg        sen_d_r;
    reg        alm_d_r;
    reg        est_d_r;
    reg        hsw_d_r;
    reg        pend_r;

    wire [2:0] tmo;
    wire [2:0] tmo_run;
    wire       to_any = |tmo;

    // ----------------------------------------------------------------
    // supervision timers: mode on, request unanswered, ready low
    // ----------------------------------------------------------------
    assign tmo_run[0] = transfer_mode_out;
    assign tmo_run[1] = position_request_out & send_ready_in;
    assign tmo_run[2] = transfer_mode_out & ~send_ready_in;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_tmr
            apt_tmr #(
                .LIMIT (gi == 0 ? MODE_CYC : (gi == 1 ? REQ_CYC : RDY_CYC))
            ) u_tmr (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (ce),
                .run     (tmo_run[gi]),
                .expired (tmo[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // trigger edges; edge flops reset low so a tied-on switch
    // looks like a rising edge on the first enabled cycle
    // ----------------------------------------------------------------
    wire sen_rise = servo_enable_in & ~sen_d_r;
    wire alm_fall = ~alarm_in & alm_d_r;
    wire est_fall = ~estop_in & est_d_r;
    wire hsw_rise = home_start_switch & ~hsw_d_r;

    // ----------------------------------------------------------------
    // apb decode; answers one cycle after setup
    // ----------------------------------------------------------------
    wire acc    = psel & penable & pready;
    wire wr_acc = acc & pwrite;
    wire hit    = (paddr == `APT_REG_CTRL)     | (paddr == `APT_REG_STATUS) |
                  (paddr == `APT_REG_POS)      | (paddr == `APT_REG_HOME)   |
                  (paddr == `APT_REG_IRQ_STAT) | (paddr == `APT_REG_IRQ_MASK) |
                  (paddr == `APT_REG_BUF_A)    | (paddr == `APT_REG_BUF_B);
    wire wr_ctrl = wr_acc & (paddr == `APT_REG_CTRL);
    wire sw_start = wr_ctrl & pwdata[`APT_CTRL_START];
    wire sw_posgo = wr_ctrl & pwdata[`APT_CTRL_POSGO];

    wire [31:0] buf_a = (AXIS == 0) ? {`APT_BUF_X_HOME, `APT_BUF_X_DIR}
                                    : {`APT_BUF_Y_HOME, `APT_BUF_Y_DIR};
    wire [31:0] buf_b = (AXIS == 0) ? {`APT_BUF_X_CMD, `APT_BUF_X_POS}
                                    : {`APT_BUF_Y_CMD, `APT_BUF_Y_POS};

    // ----------------------------------------------------------------
    // event pulses from the sequencer and the data-set home logic, gathered for status
    // ----------------------------------------------------------------
    reg  ev_done;
    reg  ev_comm;
    reg  ev_cks;
    reg  ev_home;
    wire [3:0] ev = {ev_home, ev_cks, ev_comm, ev_done};

    reg [31:0] rdata_nxt;

    // register read mux
    always @* begin
        case (paddr)
            `APT_REG_CTRL:     rdata_nxt = {28'h0, ctrl_r};
            `APT_REG_STATUS:   rdata_nxt = {21'h0, tries_r, deviation_counter_clear,
                                            torque_limit_out, zero_speed_out,
                                            in_position_out, checksum_error_out,
                                            comm_error_out, ~state_r[0],
                                            position_ready_flag};
            `APT_REG_POS:      rdata_nxt = pos_r;
            `APT_REG_HOME:     rdata_nxt = home_r;
            `APT_REG_IRQ_STAT: rdata_nxt = {28'h0, stat_r};
            `APT_REG_IRQ_MASK: rdata_nxt = {28'h0, mask_r};
            `APT_REG_BUF_A:    rdata_nxt = buf_a;
            `APT_REG_BUF_B:    rdata_nxt = buf_b;
            default:           rdata_nxt = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // apb slave, control, interrupt status and mask
    // ----------------------------------------------------------------
    wire [3:0] stat_nxt = (stat_r & ~((wr_acc && paddr == `APT_REG_IRQ_STAT) ?
                           pwdata[3:0] : 4'h0)) | ev;  // set beats clear

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            ctrl_r  <= 4'h0;
            stat_r  <= 4'h0;
            mask_r  <= 4'h0;
            irq     <= 1'b0;
        end else if (ce) begin
            pready  <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & ~pready & ~hit;
            if (psel & ~penable & ~pready)
                prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
            if (wr_ctrl)
                ctrl_r <= {1'b0, pwdata[2:1], 1'b0};   // start and go self-clear
            if (wr_acc && paddr == `APT_REG_IRQ_MASK)
                mask_r <= pwdata[3:0];
            stat_r <= stat_nxt;
            irq    <= |(stat_nxt & mask_r);
        end
    end

    // ----------------------------------------------------------------
    // status lines only mean status outside a transfer
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_position_out  <= 1'b0;
            zero_speed_out   <= 1'b0;
            torque_limit_out <= 1'b0;
            servo_on_out     <= 1'b0;
            sen_d_r          <= 1'b0;
            alm_d_r          <= 1'b0;
            est_d_r          <= 1'b0;
            hsw_d_r          <= 1'b0;
        end else if (ce) begin
            in_position_out  <= ~transfer_mode_out & data_bit0_in;
            zero_speed_out   <= ~transfer_mode_out & data_bit1_in;
            torque_limit_out <= ~transfer_mode_out & send_ready_in;
            servo_on_out     <= servo_enable_in & ~alarm_in & ~estop_in;
            sen_d_r          <= servo_enable_in;
            alm_d_r          <= alarm_in;
            est_d_r          <= estop_in;
            hsw_d_r          <= home_start_switch;
        end
    end

    // ----------------------------------------------------------------
    // transfer sequencer
    // ----------------------------------------------------------------
    wire trig = sen_rise | alm_fall | est_fall | sw_start;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r              <= S_IDLE;
            grp_r                <= 5'd0;
            pos_sh_r             <= 32'h0000_0000;
            sum_r                <= 6'h00;
            cks_r                <= 6'h00;
            tries_r              <= 3'd0;
            wait_r               <= 32'h0000_0000;
            pos_r                <= 32'h0000_0000;
            pend_r               <= 1'b0;
            transfer_mode_out    <= 1'b0;
            position_request_out <= 1'b0;
            comm_error_out       <= 1'b0;
            checksum_error_out   <= 1'b0;
            position_ready_flag  <= 1'b0;
            ev_done              <= 1'b0;
            ev_comm              <= 1'b0;
            ev_cks               <= 1'b0;
        end else if (ce) begin
            ev_done <= 1'b0;
            ev_comm <= 1'b0;
            ev_cks  <= 1'b0;
            if (trig)
                pend_r <= 1'b1;
            if (to_any && !state_r[0]) begin
                // any supervision limit ends the transfer
                comm_error_out       <= 1'b1;
                ev_comm              <= 1'b1;
                transfer_mode_out    <= 1'b0;
                position_request_out <= 1'b0;
                state_r              <= S_IDLE;
            end else begin
                case (state_r)
                    S_IDLE: begin
                        if (pend_r | trig) begin
                            pend_r              <= 1'b0;
                            position_ready_flag <= 1'b0;
                            comm_error_out      <= 1'b0;
                            checksum_error_out  <= 1'b0;
                            tries_r             <= 3'd0;
                            transfer_mode_out   <= 1'b1;
                            grp_r               <= 5'd0;
                            sum_r               <= 6'h00;
                            state_r             <= S_ARM;
                        end
                    end
                    S_ARM: begin
                        if (send_ready_in) begin
                            position_request_out <= 1'b1;
                            state_r              <= S_REQ;
                        end
                    end
                    S_REQ: begin
                        // ready low marks a valid 2-bit group
                        if (!send_ready_in) begin
                            if (grp_r < `APT_DATA_GROUPS) begin
                                pos_sh_r <= {data_bit1_in, data_bit0_in, pos_sh_r[31:2]};
                                sum_r    <= sum_r + {4'h0, data_bit1_in, data_bit0_in};
                            end else begin
                                cks_r <= {data_bit1_in, data_bit0_in, cks_r[5:2]};
                            end
                            grp_r                <= grp_r + 5'd1;
                            position_request_out <= 1'b0;
                            state_r              <= S_REL;
                        end
                    end
                    S_REL: begin
                        if (send_ready_in) begin
                            if (grp_r == `APT_ALL_GROUPS) begin
                                state_r <= S_CHK;
                            end else begin
                                position_request_out <= 1'b1;
                                state_r              <= S_REQ;
                            end
                        end
                    end
                    S_CHK: begin
                        transfer_mode_out <= 1'b0;
                        if (sum_r == cks_r) begin
                            pos_r               <= pos_sh_r;
                            position_ready_flag <= 1'b1;
                            tries_r             <= 3'd0;
                            ev_done             <= 1'b1;
                            state_r             <= S_IDLE;
                        end else if (tries_r + 3'd1 == `APT_MAX_TRIES) begin
                            checksum_error_out <= 1'b1;
                            ev_cks             <= 1'b1;
                            tries_r            <= `APT_MAX_TRIES;
                            state_r            <= S_IDLE;
                        end else begin
                            tries_r <= tries_r + 3'd1;
                            wait_r  <= RETRY_CYC;
                            state_r <= S_WAIT;
                        end
                    end
                    S_WAIT: begin
                        // mode held off long enough for the amplifier to rearm
                        if (wait_r == 32'h0000_0000) begin
                            transfer_mode_out <= 1'b1;
                            grp_r             <= 5'd0;
                            sum_r             <= 6'h00;
                            state_r           <= S_ARM;
                        end else begin
                            wait_r <= wait_r - 32'h0000_0001;
                        end
                    end
                    default: begin
                        transfer_mode_out    <= 1'b0;
                        position_request_out <= 1'b0;
                        state_r              <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // data-set home return and gated positioning start; clear is a
    // timed pulse so a stuck switch cannot hold the counter cleared
    // ----------------------------------------------------------------
    wire home_go = ctrl_r[`APT_CTRL_HOME] & ctrl_r[`APT_CTRL_REV_OK] & hsw_rise &
                   position_ready_flag & state_r[0] & ~deviation_counter_clear;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            home_r                  <= 32'h0000_0000;
            clr_r                   <= 32'h0000_0000;
            deviation_counter_clear <= 1'b0;
            position_start_out      <= 1'b0;
            ev_home                 <= 1'b0;
        end else if (ce) begin
            ev_home            <= home_go;
            position_start_out <= sw_posgo & position_ready_flag & state_r[0];
            if (home_go) begin
                home_r                  <= pos_r;
                clr_r                   <= CLR_CYC;
                deviation_counter_clear <= 1'b1;
            end else if (clr_r != 32'h0000_0000) begin
                clr_r <= clr_r - 32'h0000_0001;
            end else begin
                deviation_counter_clear <= 1'b0;
            end
        end
    end

endmodule // apt_ctrl

`default_nettype wire

//--- tb/apt_amp_model.sv
// amplifier model: shared data lines and ready handshake
`default_nettype none
module apt_amp_model (
    input  wire logic        pclk,
    input  wire logic        mode,
    input  wire logic        req,
    input  wire logic [31:0] pos,
    input  wire logic        flip,
    input  wire logic [7:0]  dly,
    input  wire logic [2:0]  stat,
    output var  logic        rdy,
    output var  logic        d0,
    output var  logic        d1
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] cks;
    logic [4:0] grp;
    logic [7:0] cnt;
    logic [1:0] g;
    initial {rdy, d1, d0} = 3'h0;
    // checksum of the 16 groups, flip corrupts it on purpose
    always_comb begin
        cks = 6'h00;
        for (int k = 0; k < 16; k++) cks = cks + 6'(pos[2*k +: 2]);
        cks = cks ^ {5'h00, flip};
        g = (grp < 5'd16) ? pos[2*grp +: 2] : cks[2*(grp-16) +: 2];
    end
    // each step waits dly cycles, so a large dly starves the controller
    always @(posedge pclk) begin
        if (!mode) begin
            {rdy, d1, d0} <= stat;
            grp <= 5'h00;
            cnt <= 8'h00;
        end else if (req != rdy) begin
            cnt <= 8'h00;
        end else if (cnt != dly) begin
            cnt <= cnt + 8'h01;
        end else if (req) begin
            {d1, d0} <= g;
            rdy <= 1'b0;
            grp <= grp + 5'h01;
        end else begin
            rdy <= 1'b1;
            {d1, d0} <= ~{d1, d0}; // data no longer held once ready returns
        end
    end
endmodule // apt_amp_model
`default_nettype wire

//--- tb/apt_ctrl_chk.sv
// assertions on the transfer controller ports
`default_nettype none
module apt_ctrl_chk #(
    parameter int MODE_CYC = 400,
    parameter int RDY_CYC  = 50,
    parameter int CLR_CYC  = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic send_ready_in,
    input wire logic transfer_mode_out,
    input wire logic position_request_out,
    input wire logic deviation_counter_clear,
    input wire logic comm_error_out,
    input wire logic checksum_error_out,
    input wire logic position_ready_flag,
    input wire logic torque_limit_out,
    input wire logic position_start_out
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CLR_TAIL = CLR_CYC - 6;
    int mode_cnt;
    int low_cnt;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // length of the current mode period and ready-low period
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_cnt <= 0;
            low_cnt <= 0;
        end else begin
            mode_cnt <= transfer_mode_out ? mode_cnt + 1 : 0;
            low_cnt <= (transfer_mode_out && !send_ready_in) ? low_cnt + 1 : 0;
        end
    end
    sequence s_clr_pulse;
        deviation_counter_clear[*8] ##CLR_TAIL !deviation_counter_clear;
    endsequence
    a_mode_bound: assert property (mode_cnt <= MODE_CYC + 4)
        else $error("transfer mode held past its limit");
    a_low_timeout: assert property (low_cnt == RDY_CYC |-> ##[0:4] comm_error_out)
        else $error("ready low too long without error");
    a_req_in_mode: assert property (position_request_out |-> transfer_mode_out)
        else $error("request outside transfer mode");
    a_req_drop: assert property ($fell(position_request_out) && !comm_error_out |-> !$past(send_ready_in))
        else $error("request dropped before ready fell");
    a_torque_masked: assert property (transfer_mode_out && $past(transfer_mode_out) |-> !torque_limit_out)
        else $error("torque status shown during transfer");
    a_torque_pass: assert property (!transfer_mode_out && !$past(transfer_mode_out) && $past(presetn)
        |-> torque_limit_out == $past(send_ready_in))
        else $error("torque status not following line");
    a_clr_pulse: assert property ($rose(deviation_counter_clear) |-> s_clr_pulse)
        else $error("clear pulse length wrong");
    a_clr_ready: assert property (deviation_counter_clear |-> position_ready_flag && !transfer_mode_out)
        else $error("clear outside home setting");
    a_go_ready: assert property (position_start_out |-> position_ready_flag)
        else $error("positioning started while not ready");
    a_start_clean: assert property ($rose(transfer_mode_out)
        |-> ##[0:2] !position_ready_flag && !comm_error_out && !checksum_error_out)
        else $error("flags not cleared at transfer start");
endmodule // apt_ctrl_chk
`default_nettype wire

//--- tb/apt_ctrl_tb.sv
// testbench for the transfer controller with amplifier model
`default_nettype none
module apt_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] POS = 32'h9c3a_51e7;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, flip = 0, ce = 1, err;
    logic servo_enable_in = 0, alarm_in = 0, estop_in = 0, home_start_switch = 0;
    logic [7:0] paddr = 8'h00, dly = 8'h01;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] stat = 3'h5;
    logic pready, pslverr, irq, send_ready_in, data_bit0_in, data_bit1_in, position_start_out;
    logic transfer_mode_out, position_request_out, deviation_counter_clear, comm_error_out;
    logic checksum_error_out, position_ready_flag, torque_limit_out;
    int fail_count = 0;
    int total_checks = 0;
    apt_ctrl #(.MODE_CYC(400), .REQ_CYC(50), .RDY_CYC(50), .RETRY_CYC(10), .CLR_CYC(10)) dut (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
        .servo_enable_in, .alarm_in, .estop_in, .home_start_switch, .send_ready_in, .data_bit0_in, .data_bit1_in,
        .servo_on_out(), .transfer_mode_out, .position_request_out, .deviation_counter_clear, .comm_error_out,
        .checksum_error_out, .position_ready_flag, .in_position_out(), .zero_speed_out(), .torque_limit_out,
        .position_start_out);
    apt_amp_model amp (.pclk, .mode(transfer_mode_out), .req(position_request_out), .pos(POS), .flip, .dly,
        .stat, .rdy(send_ready_in), .d0(data_bit0_in), .d1(data_bit1_in));
    task automatic finish_test;
        if (fail_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) begin
            fail_count++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input string nm, input logic [31:0] e, input logic [31:0] m = '1);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd & m);
    endtask
    // bounded wait for ready, checksum error, comm error or clear
    task automatic wt(input int s);
        int n;
        logic [3:0] ev;
        for (n = 0; n < 3000; n++) begin
            @(posedge pclk);
            ev = {deviation_counter_clear, comm_error_out, checksum_error_out, position_ready_flag};
            if (ev[s] === 1'b1) break;
        end
        if (n == 3000) begin
            fail_count++;
            finish_test();
        end
    endtask
    initial forever #25 pclk = ~pclk;
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rc(8'h18, "buf_a", 32'h0048_0005);
        rc(8'h1c, "buf_b", 32'h047e_0482);
        rc(8'h40, "unmapped", 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        chk("torque", 32'h1, {31'h0, torque_limit_out});
        apb(1'b1, 8'h14, 32'hf);
        servo_enable_in <= 1'b1;
        wt(0);
        rc(8'h08, "pos", POS);
        rc(8'h04, "ready", 32'h51, 32'h71);
        chk("irq_done", 32'h1, {31'h0, irq});
        apb(1'b1, 8'h00, 32'h8);
        apb(1'b1, 8'h10, 32'hf);
        repeat (2) @(posedge pclk);
        chk("irq_clr", 32'h0, {31'h0, irq});
        // corrupted checksum on every try, interrupt masked
        flip <= 1'b1;
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        wt(1);
        rc(8'h04, "cks_stat", 32'h0000_0408, 32'h0000_0709);
        apb(1'b1, 8'h00, 32'h8);
        chk("irq_masked", 32'h0, {31'h0, irq});
        rc(8'h10, "cks_event", 32'h4, 32'h4);
        apb(1'b1, 8'h14, 32'h4);
        repeat (2) @(posedge pclk);
        chk("irq_unmask", 32'h1, {31'h0, irq});
        apb(1'b1, 8'h10, 32'hf);
        // slow amplifier after alarm release
        flip <= 1'b0;
        dly <= 8'd60;
        stat <= 3'h1;
        alarm_in <= 1'b1;
        repeat (2) @(posedge pclk);
        ce <= 1'b0;
        alarm_in <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("frozen", 32'h0, {31'h0, transfer_mode_out});
        ce <= 1'b1;
        wt(2);
        rc(8'h04, "comm_stat", 32'h4, 32'h4);
        dly <= 8'h01;
        estop_in <= 1'b1;
        repeat (2) @(posedge pclk);
        estop_in <= 1'b0;
        wt(0);
        rc(8'h08, "pos_again", POS);
        // data-set home after declared revolution
        apb(1'b1, 8'h00, 32'h6);
        home_start_switch <= 1'b1;
        wt(3);
        home_start_switch <= 1'b0;
        rc(8'h0c, "home", POS);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        wt(0);
        finish_test();
    end
endmodule // apt_ctrl_tb
bind apt_ctrl apt_ctrl_chk #(.MODE_CYC(MODE_CYC), .RDY_CYC(RDY_CYC), .CLR_CYC(CLR_CYC)) u_chk (
    .pclk, .presetn, .send_ready_in, .transfer_mode_out, .position_request_out, .deviation_counter_clear,
    .comm_error_out, .checksum_error_out, .position_ready_flag, .torque_limit_out, .position_start_out);
`default_nettype wire
